// >>> common/satm_pkg.sv
// Purpose: constants for the servo fault trip and clear manager
// Assumes: 20 MHz clock, power cycle drives rst_n
// Notes: fault codes are two-digit numbers held in 7 bits
package satm_pkg;
   localparam int unsigned CLK_HZ = 20000000;
   localparam int unsigned CLR_HOLD_MS = 120;
   localparam int unsigned OVL_WAIT_S = 10;
   localparam int unsigned CLR_HOLD_CYC = (CLR_HOLD_MS * CLK_HZ + 999) / 1000;
   localparam longint unsigned OVL_WAIT_CYC = longint'(OVL_WAIT_S) * CLK_HZ;
   localparam int unsigned CODE_W = 7;
   localparam int unsigned HIST_DEPTH = 8;
   localparam int unsigned HIST_IW = 3;
   localparam int unsigned NSRC = 8;
   localparam logic [CODE_W-1:0] CODE_NONE = 7'h00;
   localparam logic [CODE_W-1:0] CODE_CUV = 7'h0b;
   localparam logic [CODE_W-1:0] CODE_OV = 7'h0c;
   localparam logic [CODE_W-1:0] CODE_MUV = 7'h0d;
   localparam logic [CODE_W-1:0] CODE_OVL = 7'h10;
   localparam logic [CODE_W-1:0] CODE_NVP = 7'h24;
   localparam logic [CODE_W-1:0] CODE_NVC = 7'h25;
   localparam logic [CODE_W-1:0] CODE_TRV = 7'h26;
   localparam logic [CODE_W-1:0] CODE_MAR = 7'h5f;
   // Overload threshold 115 percent of rated current, in percent units
   localparam logic [9:0] OVL_PCT = 10'h073;
   localparam logic [9:0] RATED_PCT = 10'h064;
   localparam logic [31:0] OVL_ACC_LIMIT = 32'h0001_0000;
   typedef enum logic [1:0] {SATM_IDLE, SATM_TRIPPED} satm_state_e;
endpackage

// >>> rtl/satm_overload.sv
// Purpose: overload time-limit integrator
// Assumes: current given as percent of rated, once per clock
// Notes: accumulator drains by one per cycle below threshold; reset (control power off) clears it
`timescale 1ns/1ps
module satm_overload
   import satm_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [9:0] current_pct,
   output logic overload
);
   logic [31:0] acc_q;
   logic [31:0] acc_d;
   wire above = current_pct >= OVL_PCT;
   wire [31:0] excess = {22'h000000, current_pct - RATED_PCT};
   // Larger excess trips faster: inverse time characteristic
   always_comb begin
      acc_d = acc_q;
      if (above) begin
         acc_d = (acc_q >= OVL_ACC_LIMIT) ? acc_q : acc_q + excess;
      end else if (acc_q != 32'h0000_0000) begin
         acc_d = acc_q - 32'h0000_0001;
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         acc_q <= 32'h0000_0000;
      end else begin
         acc_q <= acc_d;
      end
   end
   assign overload = above && (acc_q >= OVL_ACC_LIMIT);
endmodule

// >>> rtl/satm_top.sv
// Purpose: protective trip latch, clear control and fault history
// Assumes: fault inputs are synchronous levels; rst_n is power cycle
// Notes:
// Functional notes
// - Any protection trips motor, fault output off
// - Show code while tripped, refuse energize
// - Clear needs clear input held 120 ms
// - Overload trips at 115 percent via time-limit
// - Overload clear ignored for 10 seconds
// - Power removal resets overload accumulation
// - Panel and host commands also clear
// - Non-clearable faults cleared only by power cycle
// - Codes 11 and 13 not logged
// - Codes 36, 37, 38 not logged
// - Codes 95 and 97 not logged
// - Control undervoltage trips with code 11
// - Bus overvoltage trips with code 12
// - Main undervoltage code 13 only when energized
`timescale 1ns/1ps
module satm_top
   import satm_pkg::*;
#(
   parameter longint unsigned OVL_WAIT = satm_pkg::OVL_WAIT_CYC,
   parameter int unsigned CLR_HOLD = satm_pkg::CLR_HOLD_CYC
)(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ctrl_uv,
   input wire logic bus_ov,
   input wire logic main_uv,
   input wire logic [9:0] current_pct,
   input wire logic nv_param_err,
   input wire logic nv_check_err,
   input wire logic travel_err,
   input wire logic motor_recog_err,
   input wire logic [satm_pkg::CODE_W-1:0] recog_code,
   input wire logic servo_on_req,
   input wire logic fault_clear_input,
   input wire logic panel_clear,
   input wire logic host_clear,
   input wire logic [satm_pkg::HIST_IW-1:0] hist_rd_idx,
   output logic servo_fault_output_n,
   output logic motor_enable,
   output logic [satm_pkg::CODE_W-1:0] display_code,
   output logic tripped,
   output logic [satm_pkg::CODE_W-1:0] hist_rd_code,
   output logic [satm_pkg::HIST_IW:0] hist_count
);
   import satm_pkg::*;

   // Decides whether a code may be entered in history
   function automatic logic loggable(input logic [CODE_W-1:0] c);
      loggable = !(c == CODE_CUV || c == CODE_MUV
                || c == CODE_NVP || c == CODE_NVC || c == CODE_TRV
                || c == CODE_MAR || c == 7'h61);
   endfunction
   // Non-clearable codes; power cycle only
   function automatic logic sticky_code(input logic [CODE_W-1:0] c);
      sticky_code = (c == CODE_NVP) || (c == CODE_NVC) || (c == CODE_MAR) || (c == 7'h61);
   endfunction

   satm_state_e state_q, state_d;
   logic [CODE_W-1:0] code_q;
   logic [31:0] hold_cnt_q;
   logic [63:0] ovl_cnt_q;
   logic [CODE_W-1:0] hist_q [HIST_DEPTH];
   logic [HIST_IW-1:0] wr_ptr_q;
   logic [HIST_IW:0] count_q;
   logic energized_q;
   logic overload;
   logic [CODE_W-1:0] src_code [NSRC];
   logic [NSRC-1:0] src_act;

   satm_overload u_ovl (
      .clk(clk),
      .rst_n(rst_n),
      .current_pct(current_pct),
      .overload(overload)
   );

   // Sources in priority order, lowest index wins
   assign src_act = {motor_recog_err, travel_err, nv_check_err, nv_param_err,
                     overload, energized_q & main_uv, bus_ov, ctrl_uv};
   assign src_code[0] = CODE_CUV;
   assign src_code[1] = CODE_OV;
   assign src_code[2] = CODE_MUV;
   assign src_code[3] = CODE_OVL;
   assign src_code[4] = CODE_NVP;
   assign src_code[5] = CODE_NVC;
   assign src_code[6] = CODE_TRV;
   assign src_code[7] = recog_code;

   logic [CODE_W-1:0] new_code;
   always_comb begin
      new_code = CODE_NONE;
      for (int i = NSRC - 1; i >= 0; i--) begin
         if (src_act[i]) begin
            new_code = src_code[i];
         end
      end
   end

   wire any_fault = |src_act;
   wire is_tripped = (state_q == SATM_TRIPPED);
   wire hold_done = fault_clear_input && (hold_cnt_q >= CLR_HOLD - 1);
   wire ovl_ok = (code_q != CODE_OVL) || (ovl_cnt_q >= OVL_WAIT);
   wire clear_req = hold_done || panel_clear || host_clear;
   wire clear_ok = is_tripped && clear_req && ovl_ok && !sticky_code(code_q);
   wire do_trip = !is_tripped && any_fault;
   wire do_log = do_trip && loggable(new_code);

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         SATM_IDLE: if (any_fault) state_d = SATM_TRIPPED;
         SATM_TRIPPED: if (clear_ok) state_d = SATM_IDLE;
         default: state_d = SATM_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= SATM_IDLE;
         code_q <= CODE_NONE;
      end else begin
         state_q <= state_d;
         if (do_trip) begin
            code_q <= new_code;
         end else if (clear_ok) begin
            code_q <= CODE_NONE;
         end
      end
   end

   // Counter saturates so a long hold keeps hold_done true until the clear input is released
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hold_cnt_q <= 32'h0000_0000;
      end else if (!fault_clear_input) begin
         hold_cnt_q <= 32'h0000_0000;
      end else if (hold_cnt_q < CLR_HOLD) begin
         hold_cnt_q <= hold_cnt_q + 32'h0000_0001;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ovl_cnt_q <= 64'h0;
      end else if (do_trip) begin
         ovl_cnt_q <= 64'h0;
      end else if (is_tripped && ovl_cnt_q < OVL_WAIT) begin
         ovl_cnt_q <= ovl_cnt_q + 64'h1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr_q <= 3'h0;
         count_q <= 4'h0;
      end else if (do_log) begin
         wr_ptr_q <= wr_ptr_q + 3'h1;
         if (count_q < 4'(HIST_DEPTH)) count_q <= count_q + 4'h1;
      end
   end

   for (genvar g = 0; g < HIST_DEPTH; g++) begin : g_hist
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            hist_q[g] <= CODE_NONE;
         end else if (do_log && wr_ptr_q == 3'(g)) begin
            hist_q[g] <= new_code;
         end
      end
   end

   // Energize refused on the trip edge itself, not a cycle later
   wire energize_d = servo_on_req && !any_fault && state_d == SATM_IDLE;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         energized_q <= 1'b0;
         servo_fault_output_n <= 1'b0;
         motor_enable <= 1'b0;
         display_code <= CODE_NONE;
         tripped <= 1'b0;
         hist_rd_code <= CODE_NONE;
         hist_count <= 4'h0;
      end else begin
         energized_q <= energize_d;
         motor_enable <= energize_d;
         servo_fault_output_n <= (state_d == SATM_IDLE);
         display_code <= do_trip ? new_code : (clear_ok ? CODE_NONE : code_q);
         tripped <= (state_d == SATM_TRIPPED);
         hist_rd_code <= hist_q[hist_rd_idx];
         hist_count <= count_q;
      end
   end

   property p_trip_drops;
      @(posedge clk) disable iff (!rst_n) (!is_tripped && any_fault) |=> (!servo_fault_output_n && !motor_enable);
   endproperty
   a_trip_drops: assert property (p_trip_drops) else $error("fault output not dropped on trip");

   property p_no_energize;
      @(posedge clk) disable iff (!rst_n) tripped |-> !motor_enable;
   endproperty
   a_no_energize: assert property (p_no_energize) else $error("motor energized while tripped");

   property p_short_hold;
      @(posedge clk) disable iff (!rst_n)
         (is_tripped && !panel_clear && !host_clear && hold_cnt_q < CLR_HOLD - 1) |=> tripped;
   endproperty
   a_short_hold: assert property (p_short_hold) else $error("cleared before hold time");

   property p_ovl_wait;
      @(posedge clk) disable iff (!rst_n) (is_tripped && code_q == CODE_OVL && ovl_cnt_q < OVL_WAIT) |=> tripped;
   endproperty
   a_ovl_wait: assert property (p_ovl_wait) else $error("overload cleared too early");

   property p_sticky;
      @(posedge clk) disable iff (!rst_n) (is_tripped && sticky_code(code_q)) |=> $stable(code_q) && tripped;
   endproperty
   a_sticky: assert property (p_sticky) else $error("non-clearable fault cleared");

   property p_nolog;
      @(posedge clk) disable iff (!rst_n) (do_trip && !loggable(new_code)) |=> $stable(wr_ptr_q);
   endproperty
   a_nolog: assert property (p_nolog) else $error("excluded code logged");

   property p_cuv_code;
      @(posedge clk) disable iff (!rst_n) (!is_tripped && ctrl_uv) |=> display_code == CODE_CUV;
   endproperty
   a_cuv_code: assert property (p_cuv_code) else $error("wrong code for control undervoltage");

   property p_muv_gate;
      // Raw main_uv, since the gated source bit is already zero while off
      @(posedge clk) disable iff (!rst_n)
         (!is_tripped && !energized_q && main_uv && src_act == 8'h00) |=> !tripped;
   endproperty
   a_muv_gate: assert property (p_muv_gate) else $error("main undervoltage tripped while off");

   property p_latched;
      @(posedge clk) disable iff (!rst_n) (is_tripped && !clear_req) |=> tripped && $stable(display_code);
   endproperty
   a_latched: assert property (p_latched) else $error("trip not latched");
endmodule

// >>> verif/satm_host_model.sv
// Purpose: host controller model facing the fault output and clear input
// Assumes: host changes its pins just after falling clock edges
// Notes: hold length is chosen per call, so short and long holds are both possible
`timescale 1ns/1ps
module satm_host_model (
   input wire logic clk,
   input wire logic servo_fault_output_n,
   output logic fault_clear_input
);
   int alarms;
   initial begin
      fault_clear_input = 1'b0;
      alarms = 0;
   end
   // Host counts alarm entries it sees on the fault line
   always @(negedge servo_fault_output_n) begin
      alarms++;
   end
   task automatic hold_clear(input int n);
      @(negedge clk);
      fault_clear_input = 1'b1;
      repeat (n) @(negedge clk);
      fault_clear_input = 1'b0;
   endtask
endmodule

// >>> verif/tb.sv
// Purpose: self-checking bench for the trip and clear manager
// Assumes: short wait counts, 50 overload cycles and 10 clear cycles
// Notes: reset doubles as the power cycle
`timescale 1ns/1ps
module tb;
   import satm_pkg::*;
   localparam longint unsigned OVW = 50;
   localparam int unsigned CLH = 10;
   logic clk, rst_n, ctrl_uv, bus_ov, main_uv, nv_param_err, nv_check_err, travel_err;
   logic motor_recog_err, servo_on_req, panel_clear, host_clear, fault_clear_input;
   logic servo_fault_output_n, motor_enable, tripped;
   logic [9:0] current_pct;
   logic [CODE_W-1:0] recog_code, display_code, hist_rd_code;
   logic [HIST_IW-1:0] hist_rd_idx;
   logic [HIST_IW:0] hist_count;
   int err_total, compares;
   satm_top #(.OVL_WAIT(OVW), .CLR_HOLD(CLH)) i_dut (.clk(clk), .rst_n(rst_n), .ctrl_uv(ctrl_uv),
      .bus_ov(bus_ov), .main_uv(main_uv), .current_pct(current_pct), .nv_param_err(nv_param_err),
      .nv_check_err(nv_check_err), .travel_err(travel_err), .motor_recog_err(motor_recog_err),
      .recog_code(recog_code), .servo_on_req(servo_on_req), .fault_clear_input(fault_clear_input),
      .panel_clear(panel_clear), .host_clear(host_clear), .hist_rd_idx(hist_rd_idx),
      .servo_fault_output_n(servo_fault_output_n), .motor_enable(motor_enable),
      .display_code(display_code), .tripped(tripped), .hist_rd_code(hist_rd_code), .hist_count(hist_count));
   satm_host_model u_host (.clk(clk), .servo_fault_output_n(servo_fault_output_n),
      .fault_clear_input(fault_clear_input));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic end_of_test;
      $display("errors %0d compares %0d", err_total, compares);
      if (err_total == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic power_cycle;
      rst_n = 1'b0;
      cyc(8);
      rst_n = 1'b1;
      cyc(2);
   endtask
   task automatic trip_chk(input logic [CODE_W-1:0] code);
      chk(tripped, 1'b1);
      chk(servo_fault_output_n, 1'b0);
      chk(motor_enable, 1'b0);
      chk(display_code, code);
   endtask
   task automatic t_cuv;
      logic [HIST_IW:0] h0;
      int a0;
      h0 = hist_count;
      a0 = u_host.alarms;
      ctrl_uv = 1'b1;
      cyc(1);
      ctrl_uv = 1'b0;
      servo_on_req = 1'b1;
      cyc(3);
      trip_chk(CODE_CUV);
      chk(u_host.alarms, a0 + 1);
      // Cause is gone, trip must still stand
      u_host.hold_clear(CLH - 1);
      cyc(3);
      chk(display_code, CODE_CUV);
      chk(motor_enable, 1'b0);
      u_host.hold_clear(CLH + 1);
      cyc(3);
      chk(tripped, 1'b0);
      chk(servo_fault_output_n, 1'b1);
      chk(motor_enable, 1'b1);
      chk(hist_count, h0);
      servo_on_req = 1'b0;
   endtask
   task automatic t_ov;
      logic [HIST_IW:0] h0;
      for (int k = 0; k < 2; k++) begin
         h0 = hist_count;
         bus_ov = 1'b1;
         cyc(1);
         bus_ov = 1'b0;
         cyc(2);
         trip_chk(CODE_OV);
         chk(hist_count, h0 + 1);
         hist_rd_idx = h0[HIST_IW-1:0];
         cyc(2);
         chk(hist_rd_code, CODE_OV);
         panel_clear = (k == 0);
         host_clear = (k == 1);
         cyc(1);
         panel_clear = 1'b0;
         host_clear = 1'b0;
         cyc(2);
         chk(tripped, 1'b0);
      end
   endtask
   task automatic t_muv;
      logic [HIST_IW:0] h0;
      main_uv = 1'b1;
      cyc(4);
      chk(tripped, 1'b0);
      main_uv = 1'b0;
      servo_on_req = 1'b1;
      cyc(3);
      h0 = hist_count;
      main_uv = 1'b1;
      cyc(1);
      main_uv = 1'b0;
      servo_on_req = 1'b0;
      cyc(2);
      trip_chk(CODE_MUV);
      chk(hist_count, h0);
      host_clear = 1'b1;
      cyc(1);
      host_clear = 1'b0;
      cyc(2);
      chk(tripped, 1'b0);
   endtask
   task automatic t_nolog;
      logic [CODE_W-1:0] codes [5] = '{CODE_NVP, CODE_NVC, CODE_TRV, CODE_MAR, 7'h61};
      logic [HIST_IW:0] h0;
      for (int k = 0; k < 5; k++) begin
         h0 = hist_count;
         nv_param_err = (k == 0);
         nv_check_err = (k == 1);
         travel_err = (k == 2);
         motor_recog_err = (k > 2);
         recog_code = codes[k];
         cyc(1);
         {nv_param_err, nv_check_err, travel_err, motor_recog_err} = 4'h0;
         cyc(2);
         trip_chk(codes[k]);
         chk(hist_count, h0);
         u_host.hold_clear(CLH + 1);
         cyc(3);
         chk(tripped, k != 2);
         power_cycle();
      end
   endtask
   task automatic t_ovl;
      int n;
      current_pct = 10'h072;
      // Long enough that a threshold one percent low would trip
      cyc(5000);
      chk(tripped, 1'b0);
      // Partial heating, then power loss must forget it
      current_pct = 10'h0c8;
      cyc(300);
      power_cycle();
      // Kept heat plus this span would pass the limit
      cyc(400);
      chk(tripped, 1'b0);
      n = 0;
      while (tripped !== 1'b1 && n < 3000) begin
         cyc(1);
         n++;
      end
      current_pct = 10'h064;
      cyc(2);
      trip_chk(CODE_OVL);
      host_clear = 1'b1;
      cyc(1);
      host_clear = 1'b0;
      cyc(2);
      chk(tripped, 1'b1);
      cyc(OVW);
      u_host.hold_clear(CLH + 1);
      cyc(3);
      chk(tripped, 1'b0);
   endtask
   initial begin
      err_total = 0;
      compares = 0;
      rst_n = 1'b0;
      {ctrl_uv, bus_ov, main_uv, nv_param_err, nv_check_err, travel_err} = 6'h00;
      {motor_recog_err, servo_on_req, panel_clear, host_clear} = 4'h0;
      current_pct = 10'h000;
      recog_code = 7'h00;
      hist_rd_idx = 3'h0;
      cyc(8);
      rst_n = 1'b1;
      cyc(2);
      chk(servo_fault_output_n, 1'b1);
      t_cuv();
      t_ov();
      t_muv();
      t_nolog();
      t_ovl();
      end_of_test();
   end
   // Longest path is the overload run, well under this span
   initial begin
      #(20000 * 50);
      err_total++;
      end_of_test();
   end
endmodule
